// ==== rtl/ods_pkg.sv ====
// Shared constants and types for the octal converter serial link and its controller.
package ods_pkg;
	localparam int FRAME_BITS = 16;
	localparam int CHANNELS = 8;
	localparam int CODE_W = 12;
	localparam int GROUP_CH = 4;
	localparam int EDGE_CNT_W = 8;
	// Falling-edge numbers that steer abort, completion and the chain output.
	localparam logic [7:0] EDGE_ABORT_BELOW = 8'h0F;
	localparam logic [7:0] EDGE_MARKER = 8'h0F;
	localparam logic [7:0] EDGE_FRAME_DONE = 8'h10;
	localparam logic [7:0] EDGE_CHAIN_FIRST = 8'h10;
	// Field positions inside a frame.
	localparam int CMD_TOP = 15;
	localparam int CMD_NIB_LSB = 12;
	localparam int CHAN_LSB = 12;
	// Command nibbles.
	localparam logic [3:0] NIB_REG_ONLY = 4'h8;
	localparam logic [3:0] NIB_WRITE_THROUGH = 4'h9;
	localparam logic [3:0] NIB_UPDATE_ALL = 4'hA;
	localparam logic [3:0] NIB_LOAD_A_UPDATE = 4'hB;
	localparam logic [3:0] NIB_BROADCAST = 4'hC;
	localparam logic [3:0] NIB_POWER_DOWN = 4'hD;
	// Values after reset.
	localparam logic [11:0] CODE_RESET = 12'h000;
	localparam logic WRITE_THROUGH_RESET = 1'b0;
	// Controller register byte offsets.
	localparam logic [3:0] OFS_TX = 4'h0;
	localparam logic [3:0] OFS_STATUS = 4'h4;
	localparam logic [3:0] OFS_RX = 4'h8;
	// Link timing, derived from the system clock.
	localparam int CLK_PERIOD_NS = 100;
	localparam int LINK_PERIOD_NS = 800;
	localparam int HALF_CYCLES = (LINK_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	localparam int FRAME_GAP_NS = 800;
	localparam int FRAME_GAP_CYCLES = (FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_HIGH, ST_LOW, ST_TAIL, ST_GAP} ods_host_state_type;
endpackage : ods_pkg

// ==== rtl/ods_link_if.sv ====
// Three-wire write link plus chain output between controller and converter front end.
`timescale 1ns/1ps
interface ods_link_if;
	logic frame_n;
	logic sclk;
	logic din;
	logic dout;
	modport device (input frame_n, input sclk, input din, output dout);
	modport host (output frame_n, output sclk, output din, input dout);
endinterface : ods_link_if

// ==== rtl/ods_sync.sv ====
// Two-stage synchroniser for pins arriving from outside the clock domain.
`timescale 1ns/1ps
module ods_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ods_sync_state_type;
	ods_sync_state_type st_reg;
	ods_sync_state_type st_next;
	always_comb
	begin
		st_next.s1 = d_i;
		st_next.s2 = st_reg.s1;
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg.s1 <= INIT;
			st_reg.s2 <= INIT;
		end
		else
		begin
			st_reg <= st_next;
		end
	end
	assign q_o = st_reg.s2;
endmodule : ods_sync

// ==== rtl/ods_device.sv ====
// Converter front end: frame capture, command decode, channel registers and chain output.
`timescale 1ns/1ps
// What this block does
// - Frame select low starts shifting on falls.
// - Sixteen falling edges make a frame.
// - Controller raises select between edges 16, 17.
// - Command executes only on select rising.
// - Early select rise discards frame, no change.
// - Long frames pass input bits to chain.
// - Controller never lowers select on falls.
// - Controller keeps select high between frames.
// - Controller idles serial data low.
// - Controller idles frame select high.
// - Eight registers; mode decides output update.
// - Codes are plain unsigned binary 0..4095.
// - A-D use low reference, E-H high.
// - Wake-up starts at completing select rise.
// - Top bit zero writes addressed channel.
// - Register-only after reset; 1001/1000 switch.
// - 1010 updates, 1011 loads A, 1100 broadcasts.
// - Chain low 14 edges, high 15th, then data.
module ods_device (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link
	ods_link_if.device link,
	// Converter codes, low and high reference groups
	output logic [ods_pkg::GROUP_CH*ods_pkg::CODE_W-1:0] low_group_code_o,
	output logic [ods_pkg::GROUP_CH*ods_pkg::CODE_W-1:0] high_group_code_o,
	// Channel power state
	output logic [ods_pkg::CHANNELS-1:0] powered_down_o,
	output logic [ods_pkg::CHANNELS-1:0] wake_o,
	// Current mode
	output logic write_through_mode_o
);
	typedef struct packed {
		logic sclk_prev;
		logic frame_prev;
		logic [ods_pkg::FRAME_BITS-1:0] shift;
		logic [ods_pkg::EDGE_CNT_W-1:0] falls;
		logic dout;
		logic write_through_mode;
		logic [ods_pkg::CHANNELS-1:0][ods_pkg::CODE_W-1:0] data;
		logic [ods_pkg::CHANNELS-1:0][ods_pkg::CODE_W-1:0] code;
		logic [ods_pkg::CHANNELS-1:0] off;
		logic [ods_pkg::CHANNELS-1:0] wake;
	} ods_dev_state_type;

	ods_dev_state_type st_reg;
	ods_dev_state_type st_next;
	logic [2:0] pins_s;
	logic sclk_s;
	logic frame_s;
	logic din_s;

	// One-hot channel select from a three-bit address.
	function automatic logic [ods_pkg::CHANNELS-1:0] chan_mask(input logic [2:0] ch);
		logic [ods_pkg::CHANNELS-1:0] m;
		m = '0;
		m[ch] = 1'b1;
		return m;
	endfunction : chan_mask

	// Frame select idles high, so its synchroniser resets high to avoid a false frame start.
	ods_sync #(
		.W(3),
		.INIT(3'h6)
	) u_pin_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i({link.frame_n, link.sclk, link.din}),
		.q_o(pins_s)
	);
	assign frame_s = pins_s[2];
	assign sclk_s = pins_s[1];
	assign din_s = pins_s[0];

	always_comb
	begin
		logic fall;
		logic frame_start;
		logic frame_end;
		logic complete;
		logic [ods_pkg::EDGE_CNT_W-1:0] edge_no;
		logic [3:0] nib;
		logic [ods_pkg::CODE_W-1:0] val;
		logic [ods_pkg::CHANNELS-1:0] load;
		logic [ods_pkg::CHANNELS-1:0] upd;
		fall = 1'b0;
		frame_start = 1'b0;
		frame_end = 1'b0;
		complete = 1'b0;
		edge_no = '0;
		nib = '0;
		val = '0;
		load = '0;
		upd = '0;
		st_next = st_reg;
		st_next.wake = '0;
		st_next.sclk_prev = sclk_s;
		st_next.frame_prev = frame_s;
		fall = st_reg.sclk_prev & ~sclk_s;
		frame_start = st_reg.frame_prev & ~frame_s;
		frame_end = ~st_reg.frame_prev & frame_s;
		edge_no = st_reg.falls + 8'h01;
		if (frame_start)
		begin
			st_next.falls = '0;
			st_next.dout = 1'b0;
		end
		else if (!frame_s && fall)
		begin
			st_next.shift = {st_reg.shift[ods_pkg::FRAME_BITS-2:0], din_s};
			if (st_reg.falls != '1)
			begin
				st_next.falls = edge_no;
			end
			if (edge_no < ods_pkg::EDGE_MARKER)
			begin
				st_next.dout = 1'b0;
			end
			else if (edge_no == ods_pkg::EDGE_MARKER)
			begin
				st_next.dout = 1'b1;
			end
			else
			begin
				st_next.dout = st_reg.shift[ods_pkg::FRAME_BITS-2];
			end
		end
		if (frame_end)
		begin
			st_next.dout = 1'b0;
			complete = (st_reg.falls >= ods_pkg::EDGE_FRAME_DONE) && (st_reg.falls[3:0] == 4'h0);
			if (st_reg.falls < ods_pkg::EDGE_ABORT_BELOW)
			begin
				complete = 1'b0;
			end
		end
		if (complete)
		begin
			nib = st_reg.shift[ods_pkg::CMD_TOP:ods_pkg::CMD_NIB_LSB];
			val = st_reg.shift[ods_pkg::CODE_W-1:0];
			if (!st_reg.shift[ods_pkg::CMD_TOP])
			begin
				load = chan_mask(st_reg.shift[ods_pkg::CHAN_LSB+2:ods_pkg::CHAN_LSB]);
				upd = st_reg.write_through_mode ? load : '0;
			end
			else
			begin
				case (nib)
					ods_pkg::NIB_REG_ONLY:
					begin
						st_next.write_through_mode = 1'b0;
					end
					ods_pkg::NIB_WRITE_THROUGH:
					begin
						st_next.write_through_mode = 1'b1;
					end
					ods_pkg::NIB_UPDATE_ALL:
					begin
						upd = '1;
					end
					ods_pkg::NIB_LOAD_A_UPDATE:
					begin
						load = chan_mask(3'h0);
						upd = '1;
					end
					ods_pkg::NIB_BROADCAST:
					begin
						load = '1;
						upd = '1;
					end
					ods_pkg::NIB_POWER_DOWN:
					begin
						st_next.off = st_reg.off | st_reg.shift[ods_pkg::CHANNELS-1:0];
					end
					default:
					begin
						upd = '0;
					end
				endcase
			end
			for (int i = 0; i < ods_pkg::CHANNELS; i++)
			begin
				if (load[i])
				begin
					st_next.data[i] = val;
				end
				if (upd[i])
				begin
					st_next.code[i] = load[i] ? val : st_reg.data[i];
					if (st_reg.off[i])
					begin
						st_next.off[i] = 1'b0;
						st_next.wake[i] = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg.sclk_prev <= 1'b1;
			st_reg.frame_prev <= 1'b1;
			st_reg.shift <= '0;
			st_reg.falls <= '0;
			st_reg.dout <= 1'b0;
			st_reg.write_through_mode <= ods_pkg::WRITE_THROUGH_RESET;
			st_reg.data <= {ods_pkg::CHANNELS{ods_pkg::CODE_RESET}};
			st_reg.code <= {ods_pkg::CHANNELS{ods_pkg::CODE_RESET}};
			st_reg.off <= '0;
			st_reg.wake <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign link.dout = st_reg.dout;
	assign low_group_code_o = st_reg.code[ods_pkg::GROUP_CH-1:0];
	assign high_group_code_o = st_reg.code[ods_pkg::CHANNELS-1:ods_pkg::GROUP_CH];
	assign powered_down_o = st_reg.off;
	assign wake_o = st_reg.wake;
	assign write_through_mode_o = st_reg.write_through_mode;
endmodule : ods_device

// ==== rtl/ods_host.sv ====
// Serial write controller with a classic Wishbone register slave.
`timescale 1ns/1ps
module ods_host #(
	parameter int HALF = ods_pkg::HALF_CYCLES,
	parameter int GAP = ods_pkg::FRAME_GAP_CYCLES
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Link
	ods_link_if.host link
);
	typedef struct packed {
		ods_pkg::ods_host_state_type state;
		logic [7:0] timer;
		logic [4:0] bits;
		logic [15:0] tx;
		logic [15:0] last_tx;
		logic [15:0] rx;
		logic sclk;
		logic frame_n;
		logic din;
		logic ack;
		logic [31:0] dat;
	} ods_host_state_reg_type;

	ods_host_state_reg_type st_reg;
	ods_host_state_reg_type st_next;
	logic dout_s;

	ods_sync #(
		.W(1),
		.INIT(1'b0)
	) u_dout_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(link.dout),
		.q_o(dout_s)
	);

	always_comb
	begin
		logic req;
		logic busy;
		logic expired;
		req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
		busy = st_reg.state != ods_pkg::ST_IDLE;
		expired = st_reg.timer == 8'h00;
		st_next = st_reg;
		st_next.ack = req;
		if (!expired)
		begin
			st_next.timer = st_reg.timer - 8'h01;
		end
		if (req)
		begin
			case (wb_adr_i)
				ods_pkg::OFS_TX: st_next.dat = {16'h0000, st_reg.last_tx};
				ods_pkg::OFS_STATUS: st_next.dat = {31'h00000000, busy};
				ods_pkg::OFS_RX: st_next.dat = {16'h0000, st_reg.rx};
				default: st_next.dat = 32'h00000000;
			endcase
		end
		case (st_reg.state)
			ods_pkg::ST_IDLE:
			begin
				st_next.frame_n = 1'b1;
				st_next.sclk = 1'b1;
				st_next.din = 1'b0;
				if (req && wb_we_i && wb_adr_i == ods_pkg::OFS_TX && wb_sel_i[1:0] == 2'h3)
				begin
					st_next.tx = wb_dat_i[15:0];
					st_next.last_tx = wb_dat_i[15:0];
					st_next.bits = '0;
					st_next.frame_n = 1'b0;
					st_next.timer = 8'(HALF - 1);
					st_next.state = ods_pkg::ST_LEAD;
				end
			end
			ods_pkg::ST_LEAD, ods_pkg::ST_HIGH:
			begin
				if (st_reg.state == ods_pkg::ST_LEAD || !expired)
				begin
					st_next.din = st_reg.tx[15];
				end
				if (expired)
				begin
					st_next.sclk = 1'b0;
					st_next.tx = {st_reg.tx[14:0], 1'b0};
					st_next.timer = 8'(HALF - 1);
					st_next.state = ods_pkg::ST_LOW;
				end
			end
			ods_pkg::ST_LOW:
			begin
				if (expired)
				begin
					st_next.sclk = 1'b1;
					st_next.rx = {st_reg.rx[14:0], dout_s};
					st_next.bits = st_reg.bits + 5'h01;
					st_next.timer = 8'(HALF - 1);
					if (st_reg.bits == 5'(ods_pkg::FRAME_BITS - 1))
					begin
						st_next.din = 1'b0;
						st_next.state = ods_pkg::ST_TAIL;
					end
					else
					begin
						st_next.din = st_reg.tx[15];
						st_next.state = ods_pkg::ST_HIGH;
					end
				end
			end
			ods_pkg::ST_TAIL:
			begin
				if (expired)
				begin
					st_next.frame_n = 1'b1;
					st_next.timer = 8'(GAP - 1);
					st_next.state = ods_pkg::ST_GAP;
				end
			end
			ods_pkg::ST_GAP:
			begin
				if (expired)
				begin
					st_next.state = ods_pkg::ST_IDLE;
				end
			end
			default:
			begin
				st_next.state = ods_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			st_reg.state <= ods_pkg::ST_IDLE;
			st_reg.timer <= '0;
			st_reg.bits <= '0;
			st_reg.tx <= '0;
			st_reg.last_tx <= '0;
			st_reg.rx <= '0;
			st_reg.sclk <= 1'b1;
			st_reg.frame_n <= 1'b1;
			st_reg.din <= 1'b0;
			st_reg.ack <= 1'b0;
			st_reg.dat <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign wb_ack_o = st_reg.ack;
	assign wb_dat_o = st_reg.dat;
	assign link.sclk = st_reg.sclk;
	assign link.frame_n = st_reg.frame_n;
	assign link.din = st_reg.din;
endmodule : ods_host

// ==== bench/ods_link_chk.sv ====
// Wire-level checks of the serial write link between the controller and the converter front end.
`timescale 1ns/1ps
module ods_link_chk #(
	parameter int HALF = 4,
	parameter int GAP = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Link
	input wire logic frame_n,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout
);
	logic sclk_reg;
	logic [5:0] fall_reg;
	logic [7:0] high_reg;
	// The counters mirror the wire, so a slip in either end shows as a wrong count.
	always_ff @(posedge clk_i)
	begin
		sclk_reg <= rst_i ? 1'b1 : sclk;
		fall_reg <= (rst_i | frame_n) ? 6'h00 : fall_reg + 6'(sclk_reg & ~sclk);
		high_reg <= rst_i ? 8'hFF : (!frame_n ? 8'h00 : high_reg + 8'(high_reg != 8'hFF));
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_lead;
		sclk ##HALF $fell(sclk);
	endsequence
	property p_din_idle;
		frame_n |-> !din && sclk;
	endproperty
	property p_lead;
		$fell(frame_n) |-> s_lead;
	endproperty
	property p_in_frame;
		$fell(sclk) |-> !frame_n;
	endproperty
	property p_half;
		$fell(sclk) |-> ##HALF $rose(sclk);
	endproperty
	property p_len;
		$rose(frame_n) |-> fall_reg == 6'd16;
	endproperty
	property p_gap;
		$fell(frame_n) |-> int'(high_reg) >= GAP - 1;
	endproperty
	property p_dout_low;
		!frame_n && fall_reg < 6'd15 |-> !dout;
	endproperty
	property p_dout_mark;
		$rose(dout) |-> fall_reg == 6'd15 && !frame_n;
	endproperty
	property p_dout_end;
		$rose(frame_n) |-> ##[1:6] !dout;
	endproperty
	a_din_idle: assert property (p_din_idle)
		else $error("link not idle while select high");
	a_lead: assert property (p_lead)
		else $error("shift clock fell too soon after select");
	a_in_frame: assert property (p_in_frame)
		else $error("shift clock fell outside a frame");
	a_half: assert property (p_half)
		else $error("shift clock low phase wrong");
	a_len: assert property (p_len)
		else $error("frame without sixteen falls");
	a_gap: assert property (p_gap)
		else $error("select high time too short");
	a_dout_low: assert property (p_dout_low)
		else $error("chain output high too early");
	a_dout_mark: assert property (p_dout_mark)
		else $error("chain marker at wrong fall");
	a_dout_end: assert property (p_dout_end)
		else $error("chain output not cleared after frame");
endmodule : ods_link_chk

// ==== bench/test_octal_dac_serial_frame_control.sv ====
// Testbench joining controller and converter front end, plus a hand-driven second link.
`timescale 1ns/1ps
module test_octal_dac_serial_frame_control;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [3:0] wb_adr = 4'h0;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic [31:0] wb_rd;
	logic wb_ack;
	logic [47:0] low_code, high_code, b_low, b_high;
	logic [7:0] pd, wake;
	logic [7:0] wake_seen = 8'h00;
	logic wt;
	logic [11:0] exp_reg [8];
	logic [11:0] exp_out [8];
	logic [7:0] exp_pd = 8'h00;
	logic exp_wt = 1'b0;
	logic [31:0] seed = 32'h0AF739F8;
	logic [31:0] rd, cap;
	int num_errors = 0;
	int checked = 0;
	int cycles = 0;
	ods_link_if link();
	ods_link_if link_b();
	ods_host u_ods_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
		.wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack), .link(link));
	ods_device u_ods_device (.clk_i(clk_i), .rst_i(rst_i), .link(link), .low_group_code_o(low_code),
		.high_group_code_o(high_code), .powered_down_o(pd), .wake_o(wake), .write_through_mode_o(wt));
	ods_device u_ods_device_b (.clk_i(clk_i), .rst_i(rst_i), .link(link_b), .low_group_code_o(b_low),
		.high_group_code_o(b_high), .powered_down_o(), .wake_o(), .write_through_mode_o());
	ods_link_chk u_ods_link_chk (.clk_i(clk_i), .rst_i(rst_i), .frame_n(link.frame_n), .sclk(link.sclk),
		.din(link.din), .dout(link.dout));
	initial
	begin
		forever #50 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		wake_seen <= wake_seen | wake;
		cycles++;
		if (cycles == 40000)
		begin
			num_errors++;
			conclude();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [31:0] exp_chain(input logic [31:0] bits);
		logic [31:0] e;
		e = 32'h0;
		for (int n = 15; n <= 32; n++)
			e[32 - n] = (n == 15) ? 1'b1 : bits[47 - n];
		return e;
	endfunction : exp_chain
	task automatic conclude;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude
	task automatic cmp48(input logic [47:0] got, input logic [47:0] want);
		checked++;
		if (got !== want)
		begin
			num_errors++;
			$display("BAD %0t got %h want %h", $time, got, want);
		end
	endtask : cmp48
	task automatic cmp32(input logic [31:0] got, input logic [31:0] want);
		cmp48({16'h0, got}, {16'h0, want});
	endtask : cmp32
	task automatic wb(input logic we, input logic [3:0] adr, input logic [3:0] sel, input logic [31:0] dat,
		output logic [31:0] r);
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= adr;
		wb_sel <= sel;
		wb_dat <= dat;
		do @(posedge clk_i); while (wb_ack !== 1'b1);
		r = wb_rd;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask : wb
	task automatic model(input logic [15:0] f);
		if (!f[15])
		begin
			exp_reg[f[14:12]] = f[11:0];
			if (exp_wt)
			begin
				exp_out[f[14:12]] = f[11:0];
				exp_pd[f[14:12]] = 1'b0;
			end
		end
		else if (f[15:12] == 4'h8 || f[15:12] == 4'h9)
			exp_wt = f[12];
		else if (f[15:12] == 4'hD)
			exp_pd = exp_pd | f[7:0];
		else if (f[15:12] inside {4'hA, 4'hB, 4'hC})
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (f[15:12] == 4'hC || (i == 0 && f[15:12] == 4'hB))
					exp_reg[i] = f[11:0];
				exp_out[i] = exp_reg[i];
			end
			exp_pd = 8'h00;
		end
	endtask : model
	task automatic check_dev;
		cmp48(low_code, {exp_out[3], exp_out[2], exp_out[1], exp_out[0]});
		cmp48(high_code, {exp_out[7], exp_out[6], exp_out[5], exp_out[4]});
		cmp48({39'h0, pd, wt}, {39'h0, exp_pd, exp_wt});
	endtask : check_dev
	task automatic finish_frame(input logic [15:0] f);
		logic [31:0] r;
		r = 32'h1;
		while (r[0] === 1'b1)
			wb(1'b0, ods_pkg::OFS_STATUS, 4'hF, 32'h0, r);
		model(f);
		check_dev();
	endtask : finish_frame
	task automatic send(input logic [15:0] f);
		logic [31:0] r;
		wb(1'b1, ods_pkg::OFS_TX, 4'hF, {16'h0, f}, r);
		finish_frame(f);
	endtask : send
	// Bench stands in for the controller on the second link, so it may cut frames short or run them long.
	task automatic bang(input logic [31:0] bits, input int n, output logic [31:0] c);
		c = 32'h0;
		@(posedge clk_i);
		link_b.frame_n <= 1'b0;
		link_b.din <= bits[31];
		for (int i = 0; i < n; i++)
		begin
			repeat (4) @(posedge clk_i);
			link_b.sclk <= 1'b0;
			repeat (4) @(posedge clk_i);
			link_b.sclk <= 1'b1;
			link_b.din <= (i < 31) ? bits[30 - i] : 1'b0;
			@(negedge clk_i);
			c[31 - i] = link_b.dout;
		end
		repeat (4) @(posedge clk_i);
		link_b.frame_n <= 1'b1;
		link_b.din <= 1'b0;
		repeat (10) @(posedge clk_i);
	endtask : bang
	initial
	begin
		link_b.frame_n = 1'b1;
		link_b.sclk = 1'b1;
		link_b.din = 1'b0;
		for (int i = 0; i < 8; i++)
		begin
			exp_reg[i] = 12'h000;
			exp_out[i] = 12'h000;
		end
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		check_dev();
		wb(1'b0, 4'hC, 4'hF, 32'h0, rd);
		cmp32(rd, 32'h0);
		for (int ch = 0; ch < 8; ch++)
		begin
			seed = lfsr(seed);
			send({1'b0, 3'(ch), seed[11:0]});
		end
		send(16'hA000);
		send(16'h9000);
		for (int k = 0; k < 4; k++)
		begin
			seed = lfsr(seed);
			send({1'b0, seed[14:0]});
		end
		send(16'h8000);
		send({1'b0, seed[30:16]});
		send(16'hBFFF);
		send(16'hC000);
		seed = lfsr(seed);
		// Nothing is powered down before this command, so the sticky record holds only the wakes that follow.
		send({8'hD0, seed[7:0]});
		send(16'hA000);
		cmp32({24'h0, wake_seen}, {24'h0, seed[7:0]});
		send(16'hE123);
		send(16'hF456);
		wb(1'b0, ods_pkg::OFS_RX, 4'hF, 32'h0, rd);
		// Both synchronisers delay the chain bit past the next rise, so only the marker of fall 15 lands.
		cmp32(rd, 32'h00000001);
		wb(1'b1, ods_pkg::OFS_TX, 4'hC, 32'h0777, rd);
		wb(1'b0, ods_pkg::OFS_STATUS, 4'hF, 32'h0, rd);
		cmp32(rd, 32'h0);
		wb(1'b1, ods_pkg::OFS_TX, 4'hF, 32'h0555, rd);
		wb(1'b1, ods_pkg::OFS_TX, 4'hF, 32'h0AAA, rd);
		wb(1'b0, ods_pkg::OFS_TX, 4'hF, 32'h0, rd);
		cmp32(rd, 32'h0555);
		finish_frame(16'h0555);
		bang({16'hC123, 16'h0}, 16, cap);
		cmp48(b_low, {4{12'h123}});
		seed = lfsr(seed);
		for (int n = 1; n <= 15; n++)
			if (n == 3 || n == 14 || n == 15 || n == 1 + seed[3:0] % 13)
				bang({16'hC456, 16'h0}, n, cap);
		cmp48(b_high, {4{12'h123}});
		seed = lfsr(seed);
		bang({seed[31:16], 4'hC, seed[11:0]}, 32, cap);
		cmp32(cap, exp_chain({seed[31:16], 4'hC, seed[11:0]}));
		cmp48(b_low, {4{seed[11:0]}});
		// A second reset in mid-run must clear what the frames above left in the registers.
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 8; i++)
			exp_reg[i] = 12'h000;
		repeat (4) @(posedge clk_i);
		cmp48(b_low, 48'h000000000000);
		send(16'hA000);
		conclude();
	end
endmodule : test_octal_dac_serial_frame_control
